// ---- hdl/bridge_pm_defs.vh ----
`ifndef BRIDGE_PM_DEFS_VH
`define BRIDGE_PM_DEFS_VH

// register byte addresses
`define ADDR_BRIDGE_CTRL     8'h3C
`define ADDR_PM_CAP          8'h40
`define ADDR_PM_CSR          8'h44
`define ADDR_IRQ_STATUS      8'h80
`define ADDR_IRQ_MASK        8'h84

// bridge control upper fields
`define BC_VGA16_BIT         20
`define BC_SBR_BIT           22
`define BC_VGA16_RST         1'b0
`define BC_SBR_RST           1'b0

// power management capability fields
`define CAP_ID_LO            0
`define CAP_ID_VAL           8'h01
`define CAP_NEXT_LO          8
`define CAP_NEXT_VAL         8'h4C
`define CAP_REV_LO           16
`define CAP_REV_VAL          3'h3
`define CAP_DSI_BIT          21
`define CAP_DSI_RST          1'b0
`define CAP_AUX_LO           22
`define CAP_AUX_HI           24
`define CAP_AUX_RST          3'h7
`define CAP_D1_BIT           25
`define CAP_D1_RST           1'b1
`define CAP_D2_BIT           26
`define CAP_D2_RST           1'b1
`define CAP_PMES_LO          27
`define CAP_PMES_HI          31
`define CAP_PMES_RST         5'h1F

// power management control / status fields
`define CSR_STATE_LO         0
`define CSR_STATE_HI         1
`define CSR_STATE_RST        2'h0
`define CSR_NSR_BIT          3
`define CSR_NSR_RST          1'b1
`define CSR_PMEEN_BIT        8
`define CSR_PMEEN_RST        1'b0
`define CSR_DSEL_LO          9
`define CSR_DSEL_HI          12
`define CSR_DSEL_RST         4'h0

// power state codes
`define PS_D0                2'h0
`define PS_D1                2'h1
`define PS_D2                2'h2
`define PS_D3HOT             2'h3

// VGA I/O windows on the low ten address bits
`define VGA_A_LO             10'h3B0
`define VGA_A_HI             10'h3BB
`define VGA_B_LO             10'h3C0
`define VGA_B_HI             10'h3DF

// interrupt status bits
`define IRQ_D3_D0_BIT        0
`define IRQ_SBR_BIT          1
`define IRQ_PME_BIT          2
`define IRQ_WIDTH            3

// load port targets
`define LOAD_SEL_CAP         1'b0
`define LOAD_SEL_CSR         1'b1

`endif

// ---- hdl/bridge_ctrl_power_mgmt_regs.v ----
// Notes on behaviour
// R1: decode-width bit picks 10 or 16 bits
// R2: VGA windows 3B0-3BB and 3C0-3DF
// R3: secondary bus reset drives hot reset, port reset
// R4: upstream port resets all downstream ports
// R5: legacy bridge control bits read zero
// R6: capability id 01h, next pointer 4Ch
// R7: revision field reads 011b
// R8: device-specific init bit reads zero
// R9: aux current defaults to 111b
// R10: D1 and D2 support default one
// R11: power event support defaults 11111b
// R12: defaults replaceable by load port
// R13: power state field read-write, resets D0
// R14: D3 to D0 write causes hot reset
// R15: skip-internal-reset bit controls internal reset
// R16: event enable gates power event messages
// R17: power event status reads zero
// R18: reserved zero, data select writable, scale zero
`include "bridge_pm_defs.vh"

module bridge_ctrl_power_mgmt_regs
#(
   parameter UPSTREAM = 0,                 // 1 at the upstream port
   parameter PORTS    = 3                  // downstream reset outputs
)
(
   input  wire             CLK,            // core clock, 40 MHz
   input  wire             RST,            // async reset, active high
   input  wire             WB_CYC_I,       // wishbone cycle
   input  wire             WB_STB_I,       // wishbone strobe
   input  wire             WB_WE_I,        // write when high
   input  wire [7:0]       WB_ADR_I,       // byte address
   input  wire [3:0]       WB_SEL_I,       // byte enables
   input  wire [31:0]      WB_DAT_I,       // write data
   output reg  [31:0]      WB_DAT_O,       // read data
   output reg              WB_ACK_O,       // one-cycle acknowledge
   input  wire             LOAD_WE,        // default override strobe
   input  wire             LOAD_SEL,       // 0 capability, 1 csr
   input  wire [31:0]      LOAD_DATA,      // override image
   input  wire             IO_VALID,       // i/o address valid
   input  wire [15:0]      IO_ADDR,        // i/o address
   output reg              VGA_HIT,        // i/o address is vga
   input  wire             PME_REQ,        // power event pending
   output reg              PME_MSG,        // power event message, high while pending and enabled
   output reg              HOT_RESET,      // hot reset on the link
   output reg              INTERNAL_RESET, // internal soft reset pulse
   output reg  [PORTS-1:0] DOWNSTREAM_RESET_OUT_N, // port reset, low
   output wire             IRQ             // level interrupt
);

   // register state
   reg                  vga16;
   reg                  sbr;
   reg                  dsi;
   reg [2:0]            aux;
   reg                  d1_sup;
   reg                  d2_sup;
   reg [4:0]            pme_sup;
   reg [1:0]            pstate;
   reg                  nsr;
   reg                  pme_en;
   reg [3:0]            dsel;
   reg [`IRQ_WIDTH-1:0] irq_status;
   reg [`IRQ_WIDTH-1:0] irq_mask;
   reg                  sbr_q;
   reg [31:0]           next_rdata;

   // bus decode, write images and events
   wire                 bus_req;
   wire                 wr;
   wire                 d3_to_d0;
   wire                 soft_reset;
   wire [`IRQ_WIDTH-1:0] irq_event;
   wire [31:0]          bc_word;
   wire [31:0]          cap_word;
   wire [31:0]          csr_word;
   wire [31:0]          bc_wimg;
   wire [31:0]          csr_wimg;
   wire [31:0]          stat_wimg;
   wire [31:0]          mask_wimg;
   wire                 bc_wr;
   wire                 csr_wr;
   wire                 stat_wr;
   wire                 mask_wr;
   wire                 state_wr;
   wire                 vga_window;
   wire                 vga_upper_ok;

   // byte-lane merge used by every writable register
   // lanes without a select bit keep the old contents
   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0]  sel;
      integer      i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
         begin
            if (sel[i])
               merge[i*8 +: 8] = data[i*8 +: 8];
         end
      end
   endfunction

   // inclusive window check on the low ten address bits
   function in_window;
      input [9:0] a;
      input [9:0] lo;
      input [9:0] hi;
      begin
         in_window = (a >= lo) && (a <= hi);
      end
   endfunction

   // a request is taken while ack is low and answered one edge later
   assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;

   // writes land on the edge where the master samples ack high, so the
   // register changes together with the end of the bus cycle
   assign wr      = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O;

   // one write strobe per register
   assign bc_wr    = wr && (WB_ADR_I == `ADDR_BRIDGE_CTRL);
   assign csr_wr   = wr && (WB_ADR_I == `ADDR_PM_CSR);
   assign stat_wr  = wr && (WB_ADR_I == `ADDR_IRQ_STATUS);
   assign mask_wr  = wr && (WB_ADR_I == `ADDR_IRQ_MASK);

   // lane 0 of the csr carries the power state field
   assign state_wr = csr_wr && WB_SEL_I[0];
   assign d3_to_d0 = state_wr && (pstate == `PS_D3HOT) &&
                     (csr_wimg[`CSR_STATE_HI:`CSR_STATE_LO] == `PS_D0); // R14

   // soft reset only when the skip bit has been cleared by loading
   // the sticky event enable is not part of what it clears
   assign soft_reset = d3_to_d0 & ~nsr; // R15

   // read images; everything not named reads zero
   assign bc_word = {9'h000, sbr, 1'b0, vga16, 20'h00000}; // R5 R18

   assign cap_word = {pme_sup, d2_sup, d1_sup, aux, dsi, 1'b0, 1'b0,
                      `CAP_REV_VAL, `CAP_NEXT_VAL, `CAP_ID_VAL}; // R6 R7

   // bits 15, 14:13, 7:4 and 2 stay zero
   assign csr_word = {16'h0000, 1'b0, 2'b00, dsel, pme_en, 4'h0, nsr,
                      1'b0, pstate}; // R17 R18

   // write images: unselected lanes keep what the register reads now, except in the status image, where they are zero
   assign bc_wimg   = merge(bc_word, WB_DAT_I, WB_SEL_I);
   assign csr_wimg  = merge(csr_word, WB_DAT_I, WB_SEL_I);
   assign stat_wimg = merge(32'h00000000, WB_DAT_I, WB_SEL_I);
   assign mask_wimg = merge({29'h0000000, irq_mask}, WB_DAT_I, WB_SEL_I);

   // wishbone answer one cycle after the strobe, zero for holes
   always @*
   begin
      next_rdata = 32'h00000000;
      case (WB_ADR_I)
         `ADDR_BRIDGE_CTRL: next_rdata = bc_word;
         `ADDR_PM_CAP:      next_rdata = cap_word;
         `ADDR_PM_CSR:      next_rdata = csr_word;
         `ADDR_IRQ_STATUS:  next_rdata = {29'h0, irq_status};
         `ADDR_IRQ_MASK:    next_rdata = {29'h0, irq_mask};
         default:           next_rdata = 32'h00000000;
      endcase
   end

   // acknowledge and read data
   // read data is captured once and held until the next read
   always @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h00000000;
      end
      else
      begin
         WB_ACK_O <= bus_req;
         if (bus_req && !WB_WE_I)
            WB_DAT_O <= next_rdata;
      end
   end

   // bridge control: writes through byte lane 2 only
   always @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         vga16 <= `BC_VGA16_RST; // R1
         sbr   <= `BC_SBR_RST;   // R3
      end
      else if (soft_reset)
      begin
         vga16 <= `BC_VGA16_RST;
         sbr   <= `BC_SBR_RST;
      end
      else if (bc_wr)
      begin
         vga16 <= bc_wimg[`BC_VGA16_BIT]; // R1
         sbr   <= bc_wimg[`BC_SBR_BIT];   // R3
      end
   end

   // capability defaults: read-only to software, loadable from outside
   // bus writes to this word are dropped; only the load port reaches it
   always @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         dsi     <= `CAP_DSI_RST;  // R8
         aux     <= `CAP_AUX_RST;  // R9
         d1_sup  <= `CAP_D1_RST;   // R10
         d2_sup  <= `CAP_D2_RST;   // R10
         pme_sup <= `CAP_PMES_RST; // R11
      end
      else if (LOAD_WE && (LOAD_SEL == `LOAD_SEL_CAP))
      begin
         dsi     <= LOAD_DATA[`CAP_DSI_BIT];                 // R12
         aux     <= LOAD_DATA[`CAP_AUX_HI:`CAP_AUX_LO];      // R12
         d1_sup  <= LOAD_DATA[`CAP_D1_BIT];                  // R12
         d2_sup  <= LOAD_DATA[`CAP_D2_BIT];                  // R12
         pme_sup <= LOAD_DATA[`CAP_PMES_HI:`CAP_PMES_LO];    // R12
      end
   end

   // skip-internal-reset bit: only the load port changes it
   // bus writes to bit 3 of the csr are dropped
   always @(posedge CLK or posedge RST)
   begin
      if (RST)
         nsr <= `CSR_NSR_RST; // R15
      else if (LOAD_WE && (LOAD_SEL == `LOAD_SEL_CSR))
         nsr <= LOAD_DATA[`CSR_NSR_BIT]; // R12
   end

   // power state and data select; soft reset returns them to default
   always @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         pstate <= `CSR_STATE_RST; // R13
         dsel   <= `CSR_DSEL_RST;  // R18
      end
      else if (soft_reset)
      begin
         pstate <= `CSR_STATE_RST;
         dsel   <= `CSR_DSEL_RST;
      end
      else if (csr_wr)
      begin
         pstate <= csr_wimg[`CSR_STATE_HI:`CSR_STATE_LO]; // R13
         dsel   <= csr_wimg[`CSR_DSEL_HI:`CSR_DSEL_LO];   // R18
      end
   end

   // event enable is sticky: a soft reset leaves it alone
   always @(posedge CLK or posedge RST)
   begin
      if (RST)
         pme_en <= `CSR_PMEEN_RST; // R16
      else if (csr_wr)
         pme_en <= csr_wimg[`CSR_PMEEN_BIT]; // R16
   end

   // window match on the low ten bits; the upper six bits only count
   // in 16-bit mode, so 10-bit mode aliases every 1 KB block
   assign vga_window   = in_window(IO_ADDR[9:0], `VGA_A_LO, `VGA_A_HI) ||
                         in_window(IO_ADDR[9:0], `VGA_B_LO, `VGA_B_HI); // R2
   assign vga_upper_ok = !vga16 || (IO_ADDR[15:10] == 6'h00); // R1

   // vga decode, registered
   always @(posedge CLK or posedge RST)
   begin
      if (RST)
         VGA_HIT <= 1'b0;
      else
         VGA_HIT <= IO_VALID && vga_window && vga_upper_ok; // R1 R2
   end

   // power event message only while enabled
   // the enable is sticky, so a soft reset does not stop messages
   always @(posedge CLK or posedge RST)
   begin
      if (RST)
         PME_MSG <= 1'b0;
      else
         PME_MSG <= PME_REQ & pme_en; // R16
   end

   // resets: the d3 exit pulses hot reset but never the port pins
   // hot reset follows the bus reset bit as a level, so it lasts as
   // long as software leaves the bit set
   always @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         HOT_RESET              <= 1'b0;
         INTERNAL_RESET         <= 1'b0;
         DOWNSTREAM_RESET_OUT_N <= {PORTS{1'b1}};
         sbr_q                  <= 1'b0;
      end
      else
      begin
         HOT_RESET      <= sbr | d3_to_d0; // R3 R14
         INTERNAL_RESET <= soft_reset;     // R15
         sbr_q          <= sbr;
         if (UPSTREAM != 0)
            DOWNSTREAM_RESET_OUT_N <= {PORTS{~sbr}}; // R4
         else
            DOWNSTREAM_RESET_OUT_N <= {{(PORTS-1){1'b1}}, ~sbr}; // R3
      end
   end

   // events feeding the sticky status bits
   assign irq_event = {PME_REQ & pme_en, // power event message
                       sbr & ~sbr_q,     // bus reset bit rising
                       d3_to_d0};        // wake from d3hot

   // status: write one to clear, a new event wins over the clear
   // so an event in the clearing cycle is never lost
   always @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         irq_status <= {`IRQ_WIDTH{1'b0}};
         irq_mask   <= {`IRQ_WIDTH{1'b0}};
      end
      else
      begin
         if (stat_wr)
            irq_status <= (irq_status & ~stat_wimg[`IRQ_WIDTH-1:0]) |
                          irq_event;
         else
            irq_status <= irq_status | irq_event;
         if (mask_wr)
            irq_mask <= mask_wimg[`IRQ_WIDTH-1:0];
      end
   end

   // mask bit one lets the status bit through
   assign IRQ = |(irq_status & irq_mask);

endmodule // bridge_ctrl_power_mgmt_regs

// ---- test/bridge_pm_chk.sv ----
module bridge_pm_chk
#(
   parameter PORTS = 3 // reset outputs
)
(
   input wire             CLK,            // clock
   input wire             RST,            // reset
   input wire             WB_CYC_I,       // cycle
   input wire             WB_STB_I,       // strobe
   input wire             WB_WE_I,        // write
   input wire [7:0]       WB_ADR_I,       // address
   input wire [31:0]      WB_DAT_O,       // read data
   input wire             WB_ACK_O,       // ack
   input wire             IO_VALID,       // io valid
   input wire [15:0]      IO_ADDR,        // io address
   input wire             VGA_HIT,        // vga hit
   input wire             PME_REQ,        // event request
   input wire             PME_MSG,        // event message
   input wire             HOT_RESET,      // hot reset
   input wire             INTERNAL_RESET, // soft reset
   input wire [PORTS-1:0] DOWNSTREAM_RESET_OUT_N // port reset
);
   timeunit 1ns;
   timeprecision 100ps;
   // read answers and vga window decode
   wire       rd = WB_ACK_O && !WB_WE_I;
   wire [9:0] lo = IO_ADDR[9:0];
   wire       win = (lo >= 10'h3B0 && lo <= 10'h3BB) ||
                    (lo >= 10'h3C0 && lo <= 10'h3DF);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   ack_timing_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
      |=> WB_ACK_O) else $error("ack late");
   ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack too long");
   vga_hit_a: assert property (IO_VALID && win && !IO_ADDR[15:10]
      |=> VGA_HIT) else $error("vga missed");
   vga_miss_a: assert property (!(IO_VALID && win) |=> !VGA_HIT)
      else $error("vga false hit");
   cap_fixed_a: assert property (rd && WB_ADR_I == 8'h40
      |-> WB_DAT_O[20:0] == 21'h034C01) else $error("cap fixed bits");
   csr_zero_a: assert property (rd && WB_ADR_I == 8'h44
      |-> WB_DAT_O[31:13] == 19'h0 && WB_DAT_O[7:4] == 4'h0
      && !WB_DAT_O[2]) else $error("csr zero bits");
   bridge_zero_a: assert property (rd && WB_ADR_I == 8'h3C
      |-> WB_DAT_O[31:23] == 9'h0 && !WB_DAT_O[21])
      else $error("bridge zero bits");
   pme_cause_a: assert property (PME_MSG |-> $past(PME_REQ))
      else $error("event without request");
   port_reset_a: assert property (!DOWNSTREAM_RESET_OUT_N[0]
      |-> HOT_RESET && DOWNSTREAM_RESET_OUT_N == {PORTS{1'b0}})
      else $error("port reset");
   soft_pulse_a: assert property (INTERNAL_RESET |=> !INTERNAL_RESET)
      else $error("soft reset too long");
   cover property (rd && WB_ADR_I == 8'h40);
   cover property (INTERNAL_RESET);
   cover property (PME_MSG);
   cover property (!DOWNSTREAM_RESET_OUT_N[0]);
endmodule // bridge_pm_chk

// ---- test/cfg_host.sv ----
module cfg_host
(
   input  wire         clk,  // clock
   input  wire         ack,  // ack
   input  wire  [31:0] rdat, // read data
   output logic        cyc,  // cycle
   output logic        stb,  // strobe
   output logic        we,   // write
   output logic [7:0]  adr,  // address
   output logic [3:0]  sel,  // lanes
   output logic [31:0] wdat  // write data
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {cyc, stb, we, adr, sel, wdat} = '0;
   // one classic cycle; only the bench watchdog ends a lost answer
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      q = 'x;
      {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hF, d};
      do
         @(posedge clk);
      while (ack !== 1'b1);
      q = rdat;
      // released lines show a changed value, not the old one
      {cyc, stb, adr, wdat} <= {2'b00, ~a, ~d};
      @(posedge clk);
   endtask
endmodule // cfg_host

// ---- test/bridge_ctrl_power_mgmt_regs_test.sv ----
module bridge_ctrl_power_mgmt_regs_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam PORTS = 3;
   logic clk = 0, rst = 1, ld_we = 0, ld_sel = 0, io_valid = 0, pme_req = 0;
   logic cyc, stb, we, ack, vga_hit, pme_msg, hot_rst, int_rst, irq;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, q, ld_data = '0;
   logic [15:0] io_addr = '0;
   logic [PORTS-1:0] down_n;
   int err_total = 0, compares = 0, hot_cnt = 0, int_cnt = 0, down_cnt = 0;
   int h0, i0, d0, st = 0, csr = 8, cap = 32'hFFC34C01;
   always #12.5 clk = ~clk;
   bridge_ctrl_power_mgmt_regs #(.UPSTREAM(1), .PORTS(PORTS)) dut_u
   (
      .CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
      .WB_ACK_O(ack), .LOAD_WE(ld_we), .LOAD_SEL(ld_sel),
      .LOAD_DATA(ld_data), .IO_VALID(io_valid), .IO_ADDR(io_addr),
      .VGA_HIT(vga_hit), .PME_REQ(pme_req), .PME_MSG(pme_msg),
      .HOT_RESET(hot_rst), .INTERNAL_RESET(int_rst),
      .DOWNSTREAM_RESET_OUT_N(down_n), .IRQ(irq)
   );
   cfg_host host_u
   (
      .clk(clk), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb), .we(we),
      .adr(adr), .sel(sel), .wdat(wdat)
   );
   // pulse counters, since reset outputs may last one cycle
   always @(posedge clk)
   begin
      hot_cnt <= hot_cnt + hot_rst;
      int_cnt <= int_cnt + int_rst;
      down_cnt <= down_cnt + (down_n != '1);
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host_u.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      host_u.xfer(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task automatic load(input logic s, input logic [31:0] d);
      {ld_we, ld_sel, ld_data} <= {1'b1, s, d};
      @(posedge clk);
      ld_we <= 1'b0;
      @(posedge clk);
   endtask
   // random addresses around both windows, some with high bits set
   task automatic vga(input logic w16);
      logic [15:0] a;
      logic v;
      logic [9:0] l;
      repeat (40)
      begin
         a[15:10] = ($urandom % 2) ? 6'h00 : 6'($urandom);
         l = 10'h3A0 + 10'($urandom % 72);
         a[9:0] = l;
         v = ($urandom % 4) != 0;
         {io_valid, io_addr} <= {v, a};
         @(posedge clk);
         @(negedge clk);
         chk(vga_hit, v && (!w16 || a[15:10] == 6'h00) &&
             ((l >= 10'h3B0 && l <= 10'h3BB) ||
              (l >= 10'h3C0 && l <= 10'h3DF)));
         @(posedge clk);
      end
   endtask
   task automatic d3_to_d0;
      {h0, i0, d0} = {hot_cnt, int_cnt, down_cnt};
      wr(8'h44, 32'h103);
      wr(8'h44, 32'h100);
      repeat (2) @(posedge clk);
      chk(hot_cnt > h0, 1);
      chk(down_cnt, d0);
   endtask
   task automatic wrap_up;
      $display("compares %0d, err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      #(25 * 3000);
      err_total++;
      wrap_up();
   end
   initial
   begin
      q = $urandom(44898);
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(8'h40, cap);
      rd(8'h44, csr);
      rd(8'h3C, 0);
      rd(8'h90, 0);
      pme_req <= 1'b1;
      repeat (2) @(posedge clk);
      chk(pme_msg, 0);
      pme_req <= 1'b0;
      @(posedge clk);
      wr(8'h3C, 32'hFFFFFFFF);
      st = 2;
      rd(8'h3C, 32'h00500000);
      chk(down_n, 0);
      chk(hot_rst, 1);
      chk(irq, 0);
      vga(1'b1);
      wr(8'h3C, 0);
      vga(1'b0);
      chk(down_n, 3'h7);
      wr(8'h44, 32'hFFFFFFFF);
      rd(8'h44, 32'h1F0B);
      wr(8'h40, 0);
      rd(8'h40, cap);
      wr(8'h84, 7);
      pme_req <= 1'b1;
      repeat (2) @(posedge clk);
      chk(pme_msg, 1);
      chk(irq, 1);
      pme_req <= 1'b0;
      @(posedge clk);
      d3_to_d0();
      chk(int_cnt, i0);
      rd(8'h44, 32'h108);
      rd(8'h80, st | 5);
      wr(8'h80, 7);
      rd(8'h80, 0);
      chk(irq, 0);
      load(1'b1, 0);
      rd(8'h84, 7);
      rd(8'h44, 32'h100);
      d3_to_d0();
      chk(int_cnt, i0 + 1);
      rd(8'h44, 32'h100);
      load(1'b0, 0);
      rd(8'h40, 32'h00034C01);
      wrap_up();
   end
endmodule // bridge_ctrl_power_mgmt_regs_test
bind bridge_ctrl_power_mgmt_regs bridge_pm_chk #(.PORTS(PORTS)) chk_u
(
   .CLK, .RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_O,
   .WB_ACK_O, .IO_VALID, .IO_ADDR, .VGA_HIT, .PME_REQ, .PME_MSG,
   .HOT_RESET, .INTERNAL_RESET, .DOWNSTREAM_RESET_OUT_N
);
